// *** fpg_top.sv ***
// Overview of operation
// - Period divider is a 32-bit counter; slowest output is clock over two to 32.
// - High-time counter is 32 bits wide, covering the full 32-bit range.
// - Every frame-sync pulse restarts the period counter at zero while the modulator is enabled.
// - Counters start running on a detected falling edge of frame sync.
// - Period and high time are copied from registers only at frame sync.
// - Programmed period value N gives an output period of N+1 cycles.
// - High-time counter advances once per fabric clock cycle in each period.
// - Modulator output is high for high-time cycles, then low for the rest.
// - Modulator can be disabled to save power.
// - Output pin driven by modulator, external input or constant high.
// - Source code 10 is external, 11 is modulator, 0X forces high.
// - Control bit 2 enables the modulator when set, disables when clear.
// - Upper control register has no function; writing zero changes nothing.
// - Registers use 16-bit write and read data and a 4-bit address.
// - Period and high-time counters run on the fabric clock.
// - Register writes are timed by the separate register clock.
// - Low reset input resets the whole block.
// - Read strobe returns the 16-bit addressed register on read data.
// - Ready high when the next transfer may start; master waits for it.
// - Period divisor low half at offset 4, high half at offset 6.
// - High time low half at offset 8, high half at offset A.

`timescale 1ns/100ps
`default_nettype none

module fpg_top (
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  input  wire logic                         reg_clock_in,
  input  wire logic                         block_select_in,
  input  wire logic                         reg_read_strobe_in,
  input  wire logic                         reg_write_strobe_in,
  input  wire logic [fpg_pkg::ADDR_W-1:0]   reg_address_in,
  input  wire logic [fpg_pkg::REG_W-1:0]    reg_write_data_in,
  input  wire logic                         frame_sync_in,
  input  wire logic                         external_pwm_in,
  output logic      [fpg_pkg::REG_W-1:0]    reg_read_data_out,
  output logic                              transfer_ready_out,
  output logic                              pwm_out
);

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  localparam int unsigned BUS_W = 4 + fpg_pkg::ADDR_W + fpg_pkg::REG_W;

  typedef struct packed {
    logic                       reg_clock;
    logic                       select;
    logic                       read_strobe;
    logic                       write_strobe;
    logic [fpg_pkg::ADDR_W-1:0] address;
    logic [fpg_pkg::REG_W-1:0]  write_data;
  } fpg_bus_t;

  typedef struct packed {
    logic                       valid;
    logic [fpg_pkg::IDX_W-1:0]  index;
  } fpg_decode_t;

  typedef struct packed {
    logic [fpg_pkg::NUM_REG-1:0][fpg_pkg::REG_W-1:0] regs;
    logic                                            reg_clock_prev;
    logic                                            frame_sync_prev;
    logic                                            frame_pulse;
    logic                                            ready;
    logic [fpg_pkg::REG_W-1:0]                       read_data;
    logic                                            pwm;
  } fpg_top_state_t;

  // ----------------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------------
  // Only even offsets up to the last register are mapped; anything else is
  // refused so that a stray access cannot alias onto a live register.
  function automatic fpg_decode_t decode_address(input logic [fpg_pkg::ADDR_W-1:0] addr);
    fpg_decode_t result;
    result.index = addr[fpg_pkg::ADDR_W-1:1];
    result.valid = !addr[0] && (addr <= fpg_pkg::OFS_HIGH_TIME_HIGH);
    return result;
  endfunction

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  fpg_bus_t                 bus_raw;
  fpg_bus_t                 bus_sync;
  logic [BUS_W-1:0]         bus_sync_bits;
  logic [1:0]               pin_sync_bits;
  logic                     frame_sync_s;
  logic                     external_pwm_s;

  assign bus_raw.reg_clock    = reg_clock_in;
  assign bus_raw.select       = block_select_in;
  assign bus_raw.read_strobe  = reg_read_strobe_in;
  assign bus_raw.write_strobe = reg_write_strobe_in;
  assign bus_raw.address      = reg_address_in;
  assign bus_raw.write_data   = reg_write_data_in;

  // The register clock is sampled as data, so the whole bus crosses together
  // through the same two stages. The register clock must run well below the
  // fabric clock (at most a quarter) so address and data are steady at the edge.
  fpg_sync #(
    .WIDTH    (BUS_W)
  ) u_bus_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (bus_raw),
    .sync_out (bus_sync_bits)
  );

  assign bus_sync = fpg_bus_t'(bus_sync_bits);

  fpg_sync #(
    .WIDTH    (2)
  ) u_pin_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({frame_sync_in, external_pwm_in}),
    .sync_out (pin_sync_bits)
  );

  assign frame_sync_s   = pin_sync_bits[1];
  assign external_pwm_s = pin_sync_bits[0];

  // ----------------------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------------------
  fpg_core_if core_bus ();

  fpg_counter_core u_core (
    .clock    (clock),
    .rst_b    (rst_b),
    .core_bus (core_bus)
  );

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  fpg_top_state_t state_q;
  fpg_top_state_t state_d;
  fpg_decode_t    decoded;
  logic           reg_clock_rise;
  logic           access;
  logic           do_write;
  logic           do_read;
  logic [1:0]     source_select;

  assign decoded        = decode_address(bus_sync.address);
  assign reg_clock_rise = bus_sync.reg_clock && !state_q.reg_clock_prev;
  assign access         = reg_clock_rise && bus_sync.select && state_q.ready &&
                          (bus_sync.read_strobe || bus_sync.write_strobe);
  assign do_write       = access && bus_sync.write_strobe && decoded.valid;
  assign do_read        = access && bus_sync.read_strobe;
  assign source_select  = state_q.regs[fpg_pkg::IDX_CONTROL_LOW][fpg_pkg::CTRL_SRC_HI:fpg_pkg::CTRL_SRC_LO];

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d                 = state_q;
    state_d.reg_clock_prev  = bus_sync.reg_clock;
    state_d.frame_sync_prev = frame_sync_s;

    // A falling edge of frame sync marks the frame boundary.
    state_d.frame_pulse = state_q.frame_sync_prev && !frame_sync_s;

    // Register writes land only on a register clock edge. A write and a read
    // in the same transfer both act; the read returns the old value.
    if (do_write) begin
      state_d.regs[decoded.index] = bus_sync.write_data;
    end

    if (do_read) begin
      if (decoded.valid) begin
        state_d.read_data = state_q.regs[decoded.index];
      end else begin
        state_d.read_data = fpg_pkg::REG_RESET;
      end
    end

    // Ready drops once a transfer is taken and comes back when the master
    // has released both strobes, so one strobe never acts twice.
    if (access) begin
      state_d.ready = 1'b0;
    end else if (!bus_sync.read_strobe && !bus_sync.write_strobe) begin
      state_d.ready = 1'b1;
    end

    // Output switch.
    case (source_select)
      fpg_pkg::SRC_EXTERNAL: begin
        state_d.pwm = external_pwm_s;
      end
      fpg_pkg::SRC_INTERNAL: begin
        state_d.pwm = core_bus.modulator_out;
      end
      default: begin
        state_d.pwm = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q       <= '0;
      state_q.ready <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Core hookup and outputs
  // ----------------------------------------------------------------------------
  assign core_bus.enable      = state_q.regs[fpg_pkg::IDX_CONTROL_LOW][fpg_pkg::CTRL_ENABLE_BIT];
  assign core_bus.frame_pulse = state_q.frame_pulse;
  assign core_bus.period      = {state_q.regs[fpg_pkg::IDX_PERIOD_DIVISOR_HIGH],
                                 state_q.regs[fpg_pkg::IDX_PERIOD_DIVISOR_LOW]};
  assign core_bus.high_time   = {state_q.regs[fpg_pkg::IDX_HIGH_TIME_HIGH],
                                 state_q.regs[fpg_pkg::IDX_HIGH_TIME_LOW]};

  assign reg_read_data_out  = state_q.read_data;
  assign transfer_ready_out = state_q.ready;
  assign pwm_out            = state_q.pwm;

endmodule // fpg_top

`default_nettype wire

// *** fpg_pkg.sv ***
`default_nettype none

package fpg_pkg;

  // ----------------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------------
  localparam int unsigned REG_W   = 16;
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned NUM_REG = 6;
  localparam int unsigned IDX_W   = 3;

  // ----------------------------------------------------------------------------
  // Register offsets and reset value
  // ----------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL_LOW          = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_HIGH         = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_DIVISOR_LOW   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_DIVISOR_HIGH  = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_HIGH_TIME_LOW        = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_HIGH_TIME_HIGH       = 4'hA;
  localparam logic [REG_W-1:0]  REG_RESET                = 16'h0000;

  // Index of each register in the register array (offset divided by two).
  localparam logic [IDX_W-1:0]  IDX_CONTROL_LOW          = 3'h0;
  localparam logic [IDX_W-1:0]  IDX_PERIOD_DIVISOR_LOW   = 3'h2;
  localparam logic [IDX_W-1:0]  IDX_PERIOD_DIVISOR_HIGH  = 3'h3;
  localparam logic [IDX_W-1:0]  IDX_HIGH_TIME_LOW        = 3'h4;
  localparam logic [IDX_W-1:0]  IDX_HIGH_TIME_HIGH       = 3'h5;

  // ----------------------------------------------------------------------------
  // Control field layout and source codes
  // ----------------------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT = 2;
  localparam int unsigned CTRL_SRC_HI     = 1;
  localparam int unsigned CTRL_SRC_LO     = 0;
  localparam logic [1:0]  SRC_EXTERNAL    = 2'h2;
  localparam logic [1:0]  SRC_INTERNAL    = 2'h3;

endpackage : fpg_pkg

`default_nettype wire

// *** fpg_core_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface fpg_core_if;
  logic                        enable;
  logic                        frame_pulse;
  logic [fpg_pkg::CNT_W-1:0]   period;
  logic [fpg_pkg::CNT_W-1:0]   high_time;
  logic                        modulator_out;
  logic                        running;

  modport ctrl (output enable, output frame_pulse, output period, output high_time,
                input modulator_out, input running);
  modport core (input enable, input frame_pulse, input period, input high_time,
                output modulator_out, output running);
endinterface : fpg_core_if

`default_nettype wire

// *** fpg_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module fpg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } fpg_sync_state_t;

  fpg_sync_state_t state_q;
  fpg_sync_state_t state_d;

  // The first stage feeds only the second; nothing else may look at it.
  always_comb begin
    state_d.stage1 = async_in;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stage2;

endmodule // fpg_sync

`default_nettype wire

// *** fpg_counter_core.sv ***
`timescale 1ns/100ps
`default_nettype none

module fpg_counter_core (
  input  wire logic  clock,
  input  wire logic  rst_b,
  fpg_core_if.core   core_bus
);

  typedef struct packed {
    logic [fpg_pkg::CNT_W-1:0] count;
    logic [fpg_pkg::CNT_W-1:0] period;
    logic [fpg_pkg::CNT_W-1:0] high_time;
    logic                      running;
    logic                      modulator;
  } fpg_core_state_t;

  fpg_core_state_t state_q;
  fpg_core_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (!core_bus.enable) begin
      // Idle counters do not toggle, which is where the power saving comes from.
      state_d.running = 1'b0;
      state_d.count   = '0;
    end else if (core_bus.frame_pulse) begin
      state_d.period    = core_bus.period;
      state_d.high_time = core_bus.high_time;
      state_d.count     = '0;
      state_d.running   = 1'b1;
    end else if (state_q.running) begin
      if (state_q.count == state_q.period) begin
        state_d.count = '0;
      end else begin
        state_d.count = state_q.count + 32'h0000_0001;
      end
    end
    state_d.modulator = state_d.running && (state_d.count < state_d.high_time);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign core_bus.modulator_out = state_q.modulator;
  assign core_bus.running       = state_q.running;

endmodule // fpg_counter_core

`default_nettype wire

// *** fpg_top_properties.sv ***
`timescale 1ns/100ps
`default_nettype none

module fpg_top_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        block_select_in,
  input wire logic        reg_read_strobe_in,
  input wire logic        reg_write_strobe_in,
  input wire logic [3:0]  reg_address_in,
  input wire logic [15:0] reg_write_data_in,
  input wire logic        external_pwm_in,
  input wire logic [15:0] reg_read_data_out,
  input wire logic        transfer_ready_out,
  input wire logic        pwm_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Shadow of the control bits, snooped at the ports so no internal probe is needed.
  logic [2:0] ctrl_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 3'h0;
    end else if ($fell(transfer_ready_out) && $past(block_select_in && reg_write_strobe_in
                 && reg_address_in == 4'h0, 2)) begin
      ctrl_q <= $past(reg_write_data_in[2:0], 2);
    end
  end

  AST_RESET_STATE: assert property ($rose(rst_b) |-> !pwm_out && transfer_ready_out
    && reg_read_data_out == 16'h0000) else $error("outputs wrong after reset");
  AST_READY_CAUSE: assert property ($fell(transfer_ready_out) |-> $past(block_select_in
    && (reg_read_strobe_in || reg_write_strobe_in), 3)) else $error("ready fell without a request");
  AST_READY_RETURN: assert property ($fell(reg_read_strobe_in || reg_write_strobe_in)
    |-> ##[1:6] transfer_ready_out) else $error("ready did not return");
  AST_READY_HOLD: assert property ($rose(transfer_ready_out)
    |-> $past(!reg_read_strobe_in && !reg_write_strobe_in, 2)) else $error("ready rose under a strobe");
  AST_READ_HOLD: assert property (!$fell(transfer_ready_out) |-> $stable(reg_read_data_out))
    else $error("read data changed outside a transfer");
  AST_SRC_HIGH: assert property (!ctrl_q[1] && $past(rst_b && !ctrl_q[1], 3) |-> pwm_out)
    else $error("output not forced high");
  AST_SRC_EXT: assert property (ctrl_q[1:0] == 2'h2 && $past(rst_b && ctrl_q[1:0] == 2'h2, 4)
    |-> pwm_out == $past(external_pwm_in, 3)) else $error("external source not passed");
  AST_DISABLED_LOW: assert property (ctrl_q == 3'h3 && $past(rst_b && ctrl_q == 3'h3, 3)
    |-> !pwm_out) else $error("disabled modulator not low");
endmodule // fpg_top_properties

bind fpg_top fpg_top_properties chk_u (.clock, .rst_b, .block_select_in, .reg_read_strobe_in,
  .reg_write_strobe_in, .reg_address_in, .reg_write_data_in, .external_pwm_in,
  .reg_read_data_out, .transfer_ready_out, .pwm_out);

`default_nettype wire

// *** fpg_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module fpg_host_model (
  input  wire logic        clock,
  input  wire logic        transfer_ready_out,
  input  wire logic [15:0] reg_read_data_out,
  output logic             reg_clock_in,
  output logic             block_select_in,
  output logic             reg_read_strobe_in,
  output logic             reg_write_strobe_in,
  output logic [3:0]       reg_address_in,
  output logic [15:0]      reg_write_data_in
);
  int n_stuck;
  initial begin
    n_stuck = 0;
    reg_clock_in = 1'b0;
    block_select_in = 1'b0;
    reg_read_strobe_in = 1'b0;
    reg_write_strobe_in = 1'b0;
    reg_address_in = 4'h0;
    reg_write_data_in = 16'h0000;
  end

  // The register clock stands low between transfers and stays slower than a quarter of clock.
  task automatic xfer(input logic wr, input logic [3:0] addr, input logic [15:0] data,
                      output logic [15:0] rdata);
    int k;
    @(negedge clock);
    block_select_in = 1'b1;
    reg_read_strobe_in = !wr;
    reg_write_strobe_in = wr;
    reg_address_in = addr;
    reg_write_data_in = data;
    // Address, data and strobes settle one cycle before the register clock rises.
    @(negedge clock);
    reg_clock_in = 1'b1;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (transfer_ready_out !== 1'b0 && k < 20);
    rdata = reg_read_data_out;
    reg_clock_in = 1'b0;
    block_select_in = 1'b0;
    reg_read_strobe_in = 1'b0;
    reg_write_strobe_in = 1'b0;
    reg_address_in = ~addr;
    reg_write_data_in = ~data;
    while (transfer_ready_out !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    if (k >= 20) n_stuck++;
    repeat (2) @(negedge clock);
  endtask
endmodule // fpg_host_model

`default_nettype wire

// *** test_fpg_top.sv ***
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_fpg_top;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        frame_sync_in = 1'b1;
  logic        external_pwm_in = 1'b0;
  logic        reg_clock_in, block_select_in, reg_read_strobe_in, reg_write_strobe_in;
  logic [3:0]  reg_address_in;
  logic [15:0] reg_write_data_in, reg_read_data_out;
  logic        transfer_ready_out, pwm_out;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          hi, lo;
  logic [3:0]  offs [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
  logic [15:0] pat [6] = '{16'hFFF8, 16'h0000, 16'h1234, 16'hFEDC, 16'h8001, 16'h7FFE};
  logic [15:0] codes [5] = '{16'h0006, 16'h0003, 16'h0001, 16'h0000, 16'h0005};

  always #2.5 clock = ~clock;

  fpg_top dut_u (.clock, .rst_b, .reg_clock_in, .block_select_in, .reg_read_strobe_in,
    .reg_write_strobe_in, .reg_address_in, .reg_write_data_in, .frame_sync_in,
    .external_pwm_in, .reg_read_data_out, .transfer_ready_out, .pwm_out);
  fpg_host_model host_u (.clock, .transfer_ready_out, .reg_read_data_out, .reg_clock_in,
    .block_select_in, .reg_read_strobe_in, .reg_write_strobe_in, .reg_address_in, .reg_write_data_in);

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host_u.xfer(1'b0, a, 16'h0000, q);
    `CHK(q, exp)
  endtask

  task automatic frame;
    @(negedge clock);
    frame_sync_in = 1'b0;
    @(negedge clock);
    frame_sync_in = 1'b1;
  endtask

  // Waits for a fresh rising edge, then times one whole high and low phase.
  task automatic measure(output int h, output int l);
    h = 0;
    l = 0;
    while (pwm_out !== 1'b0 && h < 70000) begin @(negedge clock); h++; end
    while (pwm_out !== 1'b1 && l < 70000) begin @(negedge clock); l++; end
    h = 0;
    l = 0;
    while (pwm_out === 1'b1 && h < 70000) begin @(negedge clock); h++; end
    while (pwm_out === 1'b0 && l < 70000) begin @(negedge clock); l++; end
  endtask

  task automatic wrap_up;
    n_mismatch += host_u.n_stuck;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #450000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(pwm_out, 1'b1)
    foreach (offs[i]) rd(offs[i], 16'h0000);
    $display("reset values done");
    foreach (offs[i]) wr(offs[i], pat[i]);
    foreach (offs[i]) rd(offs[i], pat[i]);
    wr(4'hC, 16'hBEEF);
    rd(4'hC, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h0, 16'hFFF8);
    $display("register access done");
    wr(4'h4, 16'h0009);
    wr(4'h6, 16'h0000);
    wr(4'h8, 16'h0004);
    wr(4'hA, 16'h0000);
    wr(4'h0, 16'h0007);
    frame();
    measure(hi, lo);
    `CHK(hi, 4)
    `CHK(lo, 6)
    wr(4'h4, 16'h0004);
    wr(4'h8, 16'h0002);
    measure(hi, lo);
    `CHK(hi + lo, 10)
    frame();
    measure(hi, lo);
    `CHK(hi, 2)
    `CHK(lo, 3)
    wr(4'hA, 16'h0001);
    frame();
    repeat (10) @(negedge clock);
    hi = 0;
    repeat (30) begin @(negedge clock); if (pwm_out === 1'b1) hi++; end
    `CHK(hi, 30)
    $display("modulator timing done");
    foreach (codes[i]) begin
      wr(4'h0, codes[i]);
      for (int e = 0; e < 2; e++) begin
        external_pwm_in = e[0];
        repeat (6) @(negedge clock);
        `CHK(pwm_out, codes[i][1] ? (codes[i][0] ? 1'b0 : e[0]) : 1'b1)
      end
    end
    external_pwm_in = 1'b0;
    $display("source select done");
    wr(4'hA, 16'h0000);
    wr(4'h6, 16'h0001);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0007);
    frame();
    measure(hi, lo);
    `CHK(hi, 2)
    `CHK(lo, 65535)
    $display("long period done");
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    rd(4'h6, 16'h0000);
    rd(4'h0, 16'h0000);
    `CHK(pwm_out, 1'b1)
    $display("mid-run reset done");
    wrap_up();
  end
endmodule // test_fpg_top

`default_nettype wire
